// ### logic/ars_consts.vh
`ifndef ARS_CONSTS_VH
`define ARS_CONSTS_VH

// timebase
`define ARS_CLK_MHZ 100
`define ARS_CLK_KHZ 100000

// disqualify and qualify times
`define ARS_LOCK_DISQ_MS 1000
`define ARS_REF_DISQ_MS 2500
`define ARS_LOCK_TIME_MS 1000
`define ARS_HOLD_PULSE_US 375

// mate clock cycles per 8 kHz frame at 8.192 MHz
`define ARS_MATE_NOMINAL 16'h0400

// mode pin codes {hi, lo}
`define ARS_MODE_NORMAL 2'b00
`define ARS_MODE_HOLD 2'b01
`define ARS_MODE_FREE 2'b10
`define ARS_MODE_AUTO 2'b11

// loop bandwidth codes
`define ARS_BW_1HZ8 2'b00
`define ARS_BW_922HZ 2'b01
`define ARS_BW_58HZ 2'b10

// register byte offsets
`define ARS_REG_CTRL 4'h0
`define ARS_REG_STATUS 4'h4
`define ARS_REG_MATE_CNT 4'h8

// control fields
`define ARS_CTRL_NOM_MSB 15
`define ARS_CTRL_FRAME_ONLY 16
`define ARS_CTRL_RESET 32'h0000_0400

// status fields
`define ARS_ST_SEL_LSB 0
`define ARS_ST_HOLD 2
`define ARS_ST_FAIL 3
`define ARS_ST_LOCK 4
`define ARS_ST_MVALID 5
`define ARS_ST_STATE_LSB 8

`endif

// ### logic/ars_sync2.v
`timescale 1ns/1ps
// two-flop synchroniser; only the second stage is visible
module ars_sync2 #(
   parameter W = 1
) (
   input wire clk_in,
   input wire rst_b_in,
   input wire [W-1:0] d_in,
   output wire [W-1:0] q_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end

   assign q_out = sync_q;
endmodule

// ### logic/ars_top.v
// Overview of operation
// - mode 11 auto-picks in-range input a or b
// - auto mode: failed input swaps to other one
// - both failed: holdover, selection kept
// - reset or leaving mate input prefers a
// - auto mode drives select pins: 00 a, 01 b
// - auto: both out of range gives holdover
// - coarse fail forces holdover and failure outputs; in freerun mode only the failure output
// - auto: coarse fail lasting 1 s drops lock
// - auto: coarse fail lasting 2.5 s swaps input
// - recovery under 1 s keeps lock, input
// - auto: recovery 1 to 2.5 s restarts lock time
// - auto: out of range: fail, then swap under brief holdover
// - after range swap lock follows phase window
// - valid 8 kHz mate frame enables frame sync
// - mate frame valid only at nominal cycle count
// - output frame aligns to lagging mate edge
// - secondary master tracks mate, 922 Hz bandwidth
// - frame-only locking limited to 58 Hz
// - tie correction off only in secondary master
`timescale 1ns/1ps
`include "ars_consts.vh"
module ars_top #(
   parameter [31:0] LOCK_DISQ_CYC = `ARS_LOCK_DISQ_MS * `ARS_CLK_KHZ,
   parameter [31:0] REF_DISQ_CYC = `ARS_REF_DISQ_MS * `ARS_CLK_KHZ,
   parameter [31:0] LOCK_TIME_CYC = `ARS_LOCK_TIME_MS * `ARS_CLK_KHZ,
   parameter [31:0] HOLD_PULSE_CYC = `ARS_HOLD_PULSE_US * `ARS_CLK_MHZ
) (
   // clock and reset
   input wire clk_in,
   input wire rst_b_in,
   // mode pins
   input wire op_mode_pin_hi_in,
   input wire op_mode_pin_lo_in,
   input wire secondary_master_sel_in,
   input wire hitless_recovery_sel_in,
   // input choice pins, two-way
   input wire input_choice_pin_hi_in,
   input wire input_choice_pin_lo_in,
   output wire input_choice_pin_hi_out,
   output wire input_choice_pin_lo_out,
   output wire input_choice_pin_hi_oe_out,
   output wire input_choice_pin_lo_oe_out,
   // reference monitors
   input wire input_disrupted_internal_a_in,
   input wire input_disrupted_internal_b_in,
   input wire input_freq_out_of_range_a_in,
   input wire input_freq_out_of_range_b_in,
   input wire phase_in_window_in,
   // mate card link
   input wire mate_clock_input_in,
   input wire mate_frame_input_in,
   // indications and loop control
   output reg holdover_out,
   output reg ref_fail_out,
   output reg lock_out,
   output reg [1:0] sel_ref_out,
   output reg [1:0] loop_bw_out,
   output reg tie_corr_en_out,
   output reg realign_out,
   output reg mate_sync_valid_out,
   output reg frame_pulse_8k_pos_out,
   // avalon-mm slave
   input wire [3:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   output reg [31:0] avs_readdata_out,
   output wire avs_waitrequest_out
);
   localparam [4:0] S_NORM = 5'h01;
   localparam [4:0] S_HOLD = 5'h02;
   localparam [4:0] S_FREE = 5'h04;
   localparam [4:0] S_DISQ = 5'h08;
   localparam [4:0] S_SWAP = 5'h10;

   // pins from outside pass two flops
   wire [7:0] pin_s;
   ars_sync2 #(
      .W(8)
   ) u_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .d_in({op_mode_pin_hi_in, op_mode_pin_lo_in,
             secondary_master_sel_in, hitless_recovery_sel_in,
             input_choice_pin_hi_in, input_choice_pin_lo_in,
             mate_clock_input_in, mate_frame_input_in}),
      .q_out(pin_s)
   );
   wire [1:0] mode = pin_s[7:6];
   wire secondary_master_sel = pin_s[5];
   wire hitless_recovery_sel = pin_s[4];
   wire [1:0] pin_choice = pin_s[3:2];
   wire mclk_s = pin_s[1];
   wire mfrm_s = pin_s[0];
   wire auto_md = (mode == `ARS_MODE_AUTO);

   reg [4:0] state_q;
   reg [1:0] sel_q;
   reg auto_prev_q;
   reg [31:0] disq_cnt_q;
   reg [31:0] lock_cnt_q;
   reg [31:0] pulse_cnt_q;
   reg [31:0] ctrl_q;
   reg ack_q;
   reg mclk_prev_q;
   reg mfrm_prev_q;
   reg [15:0] mcnt_q;
   reg [15:0] mlast_q;
   reg [15:0] ocnt_q;
   reg align_pend_q;
   reg mvalid_q;

   wire [15:0] nominal = ctrl_q[`ARS_CTRL_NOM_MSB:0];

   // health of input a (0) or b (1)
   function bad;
      input dis;
      input oor;
      input use_oor;
      begin
         bad = dis | (use_oor & oor);
      end
   endfunction

   wire cur_dis = sel_q[1] ? 1'b0 :
      (sel_q[0] ? input_disrupted_internal_b_in :
                  input_disrupted_internal_a_in);
   wire cur_oor = sel_q[1] ? 1'b0 :
      (sel_q[0] ? input_freq_out_of_range_b_in :
                  input_freq_out_of_range_a_in);
   wire oth_dis = sel_q[0] ? input_disrupted_internal_a_in :
                             input_disrupted_internal_b_in;
   wire oth_oor = sel_q[0] ? input_freq_out_of_range_a_in :
                             input_freq_out_of_range_b_in;
   wire a_bad = bad(input_disrupted_internal_a_in,
                    input_freq_out_of_range_a_in, 1'b1);
   wire oth_bad = bad(oth_dis, oth_oor, 1'b1);
   wire cur_bad_auto = bad(cur_dis, cur_oor, 1'b1);

   // reference selection and mode state machine
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q <= S_HOLD;
         sel_q <= 2'b00;
         auto_prev_q <= 1'b0;
         disq_cnt_q <= 32'h0000_0000;
         pulse_cnt_q <= 32'h0000_0000;
         lock_cnt_q <= 32'h0000_0000;
         lock_out <= 1'b0;
         realign_out <= 1'b0;
      end else begin
         auto_prev_q <= auto_md;
         realign_out <= 1'b0;
         // lock qualify: counts only while tracking inside window
         if (state_q == S_NORM && phase_in_window_in && !lock_out) begin
            if (lock_cnt_q >= LOCK_TIME_CYC - 32'h0000_0001)
               lock_out <= 1'b1;
            else
               lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
         end
         if (!auto_md) begin
            // manual choice from pins; oor ignored here
            sel_q <= pin_choice[1] ? 2'b10 : {1'b0, pin_choice[0]};
            disq_cnt_q <= 32'h0000_0000;
            case (mode)
               `ARS_MODE_HOLD: state_q <= S_HOLD;
               `ARS_MODE_FREE: state_q <= S_FREE;
               default: begin
                  if (cur_dis) begin
                     state_q <= S_HOLD;
                  end else begin
                     if (state_q != S_NORM && !hitless_recovery_sel)
                        realign_out <= 1'b1;
                     state_q <= S_NORM;
                  end
               end
            endcase
         end else if (!auto_prev_q && sel_q[1]) begin
            // mate input cannot be used in auto; a first
            sel_q <= a_bad ? 2'b01 : 2'b00;
            state_q <= S_HOLD;
         end else begin
            case (state_q)
               S_NORM: begin
                  if (cur_dis) begin
                     state_q <= S_DISQ;
                     disq_cnt_q <= 32'h0000_0000;
                  end else if (cur_oor && oth_bad) begin
                     state_q <= S_HOLD;
                  end else if (cur_oor) begin
                     sel_q <= {1'b0, ~sel_q[0]};
                     state_q <= S_SWAP;
                     pulse_cnt_q <= 32'h0000_0000;
                     if (!phase_in_window_in) begin
                        lock_out <= 1'b0;
                        lock_cnt_q <= 32'h0000_0000;
                     end
                  end
               end
               S_DISQ: begin
                  // timer runs on clk, dropped on recovery
                  if (!cur_dis) begin
                     state_q <= S_NORM;
                     disq_cnt_q <= 32'h0000_0000;
                  end else begin
                     if (disq_cnt_q != REF_DISQ_CYC)
                        disq_cnt_q <= disq_cnt_q + 32'h0000_0001;
                     if (disq_cnt_q == LOCK_DISQ_CYC - 32'h0000_0001) begin
                        lock_out <= 1'b0;
                        lock_cnt_q <= 32'h0000_0000;
                     end
                     if (disq_cnt_q >= REF_DISQ_CYC - 32'h0000_0001 &&
                         !oth_bad) begin
                        sel_q <= {1'b0, ~sel_q[0]};
                        state_q <= S_NORM;
                        disq_cnt_q <= 32'h0000_0000;
                        lock_out <= 1'b0;
                        lock_cnt_q <= 32'h0000_0000;
                     end
                  end
               end
               S_SWAP: begin
                  // brief holdover while the loop moves over
                  if (pulse_cnt_q >= HOLD_PULSE_CYC - 32'h0000_0001)
                     state_q <= S_NORM;
                  else
                     pulse_cnt_q <= pulse_cnt_q + 32'h0000_0001;
               end
               default: begin
                  // holdover or freerun left from manual: seek good input
                  if (!cur_bad_auto) begin
                     state_q <= S_NORM;
                  end else if (!oth_bad) begin
                     sel_q <= {1'b0, ~sel_q[0]};
                     state_q <= S_NORM;
                  end else begin
                     state_q <= S_HOLD;
                  end
               end
            endcase
         end
      end
   end

   // indications, all registered
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         holdover_out <= 1'b1;
         ref_fail_out <= 1'b0;
         sel_ref_out <= 2'b00;
         loop_bw_out <= `ARS_BW_1HZ8;
         tie_corr_en_out <= 1'b1;
      end else begin
         holdover_out <= (state_q == S_HOLD) || (state_q == S_DISQ) ||
                         (state_q == S_SWAP);
         ref_fail_out <= (state_q == S_DISQ) || (state_q == S_SWAP) ||
                         cur_dis || (auto_md && cur_oor);
         sel_ref_out <= sel_q;
         tie_corr_en_out <= !secondary_master_sel;
         if (secondary_master_sel && sel_q[1] && ctrl_q[`ARS_CTRL_FRAME_ONLY])
            loop_bw_out <= `ARS_BW_58HZ;
         else if (secondary_master_sel && sel_q[1])
            loop_bw_out <= `ARS_BW_922HZ;
         else
            loop_bw_out <= `ARS_BW_1HZ8;
      end
   end

   // select pins become outputs only in auto mode
   assign input_choice_pin_hi_out = 1'b0;
   assign input_choice_pin_lo_out = sel_q[0];
   assign input_choice_pin_hi_oe_out = auto_md;
   assign input_choice_pin_lo_oe_out = auto_md;

   // mate clock and frame checking; frame assumed made from mate clock
   wire mclk_rise = mclk_s & ~mclk_prev_q;
   wire mfrm_rise = mfrm_s & ~mfrm_prev_q;
   wire track = mvalid_q && secondary_master_sel && sel_q[1];

   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mclk_prev_q <= 1'b0;
         mfrm_prev_q <= 1'b0;
         mcnt_q <= 16'h0000;
         mlast_q <= 16'h0000;
         mvalid_q <= 1'b0;
         mate_sync_valid_out <= 1'b0;
         align_pend_q <= 1'b0;
         ocnt_q <= 16'h0000;
         frame_pulse_8k_pos_out <= 1'b0;
      end else begin
         mclk_prev_q <= mclk_s;
         mfrm_prev_q <= mfrm_s;
         mate_sync_valid_out <= mvalid_q;
         if (mfrm_rise) begin
            // a frame is good only at the exact count
            mvalid_q <= ((mclk_rise ? mcnt_q + 16'h0001 : mcnt_q) ==
                         nominal);
            mlast_q <= mclk_rise ? mcnt_q + 16'h0001 : mcnt_q;
            mcnt_q <= 16'h0000;
            align_pend_q <= 1'b1;
         end else if (mclk_rise) begin
            mcnt_q <= mcnt_q + 16'h0001;
         end
         // output frame counter steps on mate clock edges
         if (mclk_rise && !mfrm_rise) begin
            if (align_pend_q && track) begin
               ocnt_q <= 16'h0000;
               frame_pulse_8k_pos_out <= 1'b1;
            end else if (ocnt_q >= nominal - 16'h0001) begin
               ocnt_q <= 16'h0000;
               frame_pulse_8k_pos_out <= 1'b1;
            end else begin
               ocnt_q <= ocnt_q + 16'h0001;
               frame_pulse_8k_pos_out <= 1'b0;
            end
            align_pend_q <= 1'b0;
         end
      end
   end

   // avalon slave: one wait state per access
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;

   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ack_q <= 1'b0;
         ctrl_q <= `ARS_CTRL_RESET;
         avs_readdata_out <= 32'h0000_0000;
      end else begin
         ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
         if (avs_write_in && !ack_q &&
             avs_address_in == `ARS_REG_CTRL)
            ctrl_q <= {15'h0000, avs_writedata_in[16:0]};
         if (avs_read_in && !ack_q) begin
            case (avs_address_in)
               `ARS_REG_CTRL: avs_readdata_out <= ctrl_q;
               `ARS_REG_STATUS: avs_readdata_out <=
                  {19'h00000, state_q, 2'b00, mvalid_q, lock_out,
                   ref_fail_out, holdover_out, sel_q};
               `ARS_REG_MATE_CNT: avs_readdata_out <= {16'h0000, mlast_q};
               default: avs_readdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// ### verif/ars_top_asserts.sv
`timescale 1ns/1ps
module ars_top_asserts #(
   parameter [31:0] LOCK_DISQ_CYC = 100
) (
   // clock and reset
   input wire clk_in,
   input wire rst_b_in,
   // pins
   input wire op_mode_pin_hi_in,
   input wire op_mode_pin_lo_in,
   input wire secondary_master_sel_in,
   input wire input_disrupted_internal_a_in,
   input wire input_disrupted_internal_b_in,
   input wire input_choice_pin_hi_out,
   input wire input_choice_pin_lo_out,
   input wire input_choice_pin_hi_oe_out,
   input wire input_choice_pin_lo_oe_out,
   // indications and bus
   input wire holdover_out,
   input wire ref_fail_out,
   input wire lock_out,
   input wire [1:0] sel_ref_out,
   input wire tie_corr_en_out,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire avs_waitrequest_out
);
   default clocking dc @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   wire auto_pins = op_mode_pin_hi_in & op_mode_pin_lo_in;
   wire oe = input_choice_pin_lo_oe_out;
   wire both_dis = input_disrupted_internal_a_in &
      input_disrupted_internal_b_in;
   wire cur_dis = sel_ref_out[0] ? input_disrupted_internal_b_in :
      input_disrupted_internal_a_in;
   wire on_net = oe & !sel_ref_out[1];
   reg [31:0] dis_cnt_q;
   // run length of disruption on the chosen input, zero once it heals
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         dis_cnt_q <= 32'h0;
      else if (on_net && cur_dis)
         dis_cnt_q <= dis_cnt_q + 32'h1;
      else
         dis_cnt_q <= 32'h0;
   end
   a_oe_follow: assert property (
      $stable(auto_pins) [*5] |-> oe == auto_pins &&
      input_choice_pin_hi_oe_out == auto_pins)
      else $error("choice pin enables do not follow auto mode");
   a_hi_pin_zero: assert property (
      input_choice_pin_hi_oe_out |-> !input_choice_pin_hi_out)
      else $error("upper choice pin driven high");
   a_lo_pin_sel: assert property (
      oe && input_choice_pin_lo_out != sel_ref_out[0]
      |=> input_choice_pin_lo_out == sel_ref_out[0])
      else $error("lower choice pin disagrees with selection");
   a_auto_no_mate: assert property (
      oe [*5] |-> !sel_ref_out[1])
      else $error("mate input selected in auto mode");
   a_coarse_hold: assert property (
      (on_net && cur_dis) [*3] |-> holdover_out && ref_fail_out)
      else $error("coarse failure without holdover and failure");
   a_lock_drop: assert property (
      dis_cnt_q > LOCK_DISQ_CYC + 32'd3 |-> !lock_out)
      else $error("lock kept past lock disqualify time");
   a_lock_keep: assert property (
      lock_out && dis_cnt_q != 32'h0 && dis_cnt_q < LOCK_DISQ_CYC - 32'd8
      |=> lock_out)
      else $error("lock lost early in a coarse failure");
   a_both_hold: assert property (
      (oe && both_dis) [*3] |=> holdover_out && $stable(sel_ref_out))
      else $error("both inputs failed without holdover");
   a_tie_follow: assert property (
      $stable(secondary_master_sel_in) [*5]
      |-> tie_corr_en_out != secondary_master_sel_in)
      else $error("tie correction wrong for master role");
   a_one_wait: assert property (
      (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out)
      else $error("bus wait state longer than one cycle");
   c_on_b: cover property (oe && sel_ref_out == 2'b01);
   c_lock_lost: cover property (dis_cnt_q > LOCK_DISQ_CYC + 32'd3);
   c_both: cover property (oe && both_dis);
endmodule
bind ars_top ars_top_asserts #(.LOCK_DISQ_CYC(LOCK_DISQ_CYC)) u_chk (
   .clk_in, .rst_b_in, .op_mode_pin_hi_in, .op_mode_pin_lo_in,
   .secondary_master_sel_in, .input_disrupted_internal_a_in,
   .input_disrupted_internal_b_in, .input_choice_pin_hi_out,
   .input_choice_pin_lo_out, .input_choice_pin_hi_oe_out,
   .input_choice_pin_lo_oe_out, .holdover_out, .ref_fail_out, .lock_out,
   .sel_ref_out, .tie_corr_en_out, .avs_read_in, .avs_write_in,
   .avs_waitrequest_out);

// ### verif/ars_mate_card.sv
`timescale 1ns/1ps
module ars_mate_card (
   input wire en_in,
   input wire [15:0] cyc_in,
   output reg clk_out,
   output reg frame_out
);
   integer n;
   // clock stands still while disabled; frame launched on falling edge
   initial begin
      clk_out = 1'b0;
      frame_out = 1'b0;
      n = 0;
      #3;
      forever begin
         #80;
         if (en_in)
            clk_out = ~clk_out;
         if (!en_in)
            frame_out = 1'b0;
         else if (!clk_out) begin
            n = (n + 1 >= cyc_in) ? 0 : n + 1;
            frame_out = (n == 0);
         end
      end
   end
endmodule

// ### verif/tb_ars_top.sv
`timescale 1ns/1ps
module tb_ars_top;
   localparam int LDQ = 100;
   localparam int RDQ = 250;
   localparam int LKT = 50;
   localparam [8:0] F = 9'h01f;
   logic clk_in = 1'b0, rst_b_in = 1'b0;
   logic op_mode_pin_hi_in = 1'b0, op_mode_pin_lo_in = 1'b0;
   logic secondary_master_sel_in = 1'b0, hitless_recovery_sel_in = 1'b1;
   logic [1:0] chs = 2'b00;
   logic input_disrupted_internal_a_in = 1'b0;
   logic input_disrupted_internal_b_in = 1'b0;
   logic input_freq_out_of_range_a_in = 1'b0;
   logic input_freq_out_of_range_b_in = 1'b0;
   logic phase_in_window_in = 1'b1, men = 1'b0, chk = 1'b0;
   logic [15:0] mcyc = 16'h0040;
   logic [3:0] avs_address_in = 4'h0;
   logic avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   wire input_choice_pin_hi_out, input_choice_pin_lo_out;
   wire input_choice_pin_hi_oe_out, input_choice_pin_lo_oe_out;
   wire mate_clock_input_in, mate_frame_input_in, holdover_out, ref_fail_out;
   wire lock_out, tie_corr_en_out, mate_sync_valid_out, avs_waitrequest_out;
   wire frame_pulse_8k_pos_out;
   wire [1:0] sel_ref_out, loop_bw_out;
   wire [31:0] avs_readdata_out;
   // choice pins resolved from both drivers
   wire input_choice_pin_hi_in = input_choice_pin_hi_oe_out ?
      input_choice_pin_hi_out : chs[1];
   wire input_choice_pin_lo_in = input_choice_pin_lo_oe_out ?
      input_choice_pin_lo_out : chs[0];
   wire [8:0] st = {mate_sync_valid_out, tie_corr_en_out, loop_bw_out,
      holdover_out, ref_fail_out, lock_out, sel_ref_out};
   logic [63:0] exp_q[$];
   int error_cnt = 0;
   int samples_checked = 0;
   always #5 clk_in = ~clk_in;
   ars_mate_card u_mate (.en_in(men), .cyc_in(mcyc),
      .clk_out(mate_clock_input_in), .frame_out(mate_frame_input_in));
   ars_top #(.LOCK_DISQ_CYC(LDQ), .REF_DISQ_CYC(RDQ), .LOCK_TIME_CYC(LKT),
      .HOLD_PULSE_CYC(8)) DUT (
      .clk_in, .rst_b_in, .op_mode_pin_hi_in, .op_mode_pin_lo_in,
      .secondary_master_sel_in, .hitless_recovery_sel_in,
      .input_choice_pin_hi_in, .input_choice_pin_lo_in,
      .input_choice_pin_hi_out, .input_choice_pin_lo_out,
      .input_choice_pin_hi_oe_out, .input_choice_pin_lo_oe_out,
      .input_disrupted_internal_a_in, .input_disrupted_internal_b_in,
      .input_freq_out_of_range_a_in, .input_freq_out_of_range_b_in,
      .phase_in_window_in, .mate_clock_input_in, .mate_frame_input_in,
      .holdover_out, .ref_fail_out, .lock_out, .sel_ref_out, .loop_bw_out,
      .tie_corr_en_out, .realign_out(), .mate_sync_valid_out,
      .frame_pulse_8k_pos_out, .avs_address_in, .avs_read_in,
      .avs_write_in, .avs_writedata_in, .avs_readdata_out,
      .avs_waitrequest_out);
   task automatic check(input [31:0] seen, input [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic test_done;
      $display("checked=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // oldest note meets the next result seen
   always @(posedge clk_in) begin
      logic [63:0] e;
      if (chk || (avs_read_in && avs_waitrequest_out === 1'b0)) begin
         e = exp_q.pop_front();
         check((chk ? {23'h0, st} : avs_readdata_out) & e[63:32], e[31:0]);
      end
   end
   // waits for a match within lim cycles, then has it compared
   task automatic exp_st(input [8:0] m, input [8:0] e, input int lim);
      int n;
      n = 0;
      while ((st & m) !== e && n < lim) begin
         @(negedge clk_in);
         n++;
      end
      if ((st & m) !== e && lim > 0) begin
         error_cnt++;
         test_done();
      end
      exp_q.push_back({23'h0, m, 23'h0, e});
      @(posedge clk_in);
      chk <= 1'b1;
      @(posedge clk_in);
      chk <= 1'b0;
   endtask
   task automatic bus(input bit w, input [3:0] a, input [31:0] d);
      int n;
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_read_in <= !w;
      avs_write_in <= w;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 20);
      if (avs_waitrequest_out !== 1'b0) begin
         error_cnt++;
         test_done();
      end
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge clk_in);
   endtask
   // output frame period in clk cycles, rise to rise
   task automatic fp_period(input int want);
      int i, k, n;
      logic p;
      k = 0;
      n = 0;
      p = 1'b1;
      for (i = 0; i < 4000 && k < 2; i++) begin
         @(posedge clk_in);
         if (frame_pulse_8k_pos_out && !p)
            k++;
         if (k == 1)
            n++;
         p = frame_pulse_8k_pos_out;
      end
      check(n, want);
      if (k < 2) begin
         error_cnt++;
         test_done();
      end
   endtask
   task automatic rdc(input [3:0] a, input [31:0] e);
      exp_q.push_back({32'hffff_ffff, e});
      bus(1'b0, a, 32'h0);
   endtask
   task automatic mode(input [1:0] m);
      op_mode_pin_hi_in <= m[1];
      op_mode_pin_lo_in <= m[0];
   endtask
   task automatic dis(input a, input b);
      input_disrupted_internal_a_in <= a;
      input_disrupted_internal_b_in <= b;
   endtask
   task automatic oor(input a, input b);
      input_freq_out_of_range_a_in <= a;
      input_freq_out_of_range_b_in <= b;
   endtask
   initial begin
      #1_000_000;
      error_cnt++;
      test_done();
   end
   initial begin
      int d;
      void'($urandom(32'h3b10));
      repeat (4) @(posedge clk_in);
      rst_b_in <= 1'b1;
      rdc(4'h0, 32'h0000_0400);
      rdc(4'hc, 32'h0);
      exp_st(F, 9'h004, LKT + 60);
      mode(2'b11);
      exp_st(F, 9'h004, 20);
      oor(1'b1, 1'b0);
      exp_st(F, 9'h005, 100);
      oor(1'b0, 1'b0);
      repeat (20) @(posedge clk_in);
      exp_st(F, 9'h005, 0);
      oor(1'b1, 1'b1);
      exp_st(9'h01b, 9'h019, 20);
      oor(1'b0, 1'b0);
      exp_st(F, 9'h005, LKT + 60);
      // swaps outside the phase window must drop lock
      phase_in_window_in <= 1'b0;
      oor(1'b0, 1'b1);
      exp_st(F, 9'h000, 100);
      oor(1'b1, 1'b0);
      exp_st(F, 9'h001, 100);
      phase_in_window_in <= 1'b1;
      oor(1'b0, 1'b0);
      exp_st(F, 9'h005, LKT + 60);
      d = LDQ / 4 + $urandom % (LDQ / 2);
      dis(1'b0, 1'b1);
      repeat (d) @(posedge clk_in);
      exp_st(F, 9'h01d, 0);
      dis(1'b0, 1'b0);
      exp_st(F, 9'h005, 10);
      dis(1'b0, 1'b1);
      repeat (LDQ + 20) @(posedge clk_in);
      dis(1'b0, 1'b0);
      exp_st(F, 9'h001, 10);
      repeat (LKT - 15) @(posedge clk_in);
      exp_st(F, 9'h001, 0);
      exp_st(F, 9'h005, 30);
      dis(1'b0, 1'b1);
      exp_st(F, 9'h000, RDQ + 40);
      dis(1'b0, 1'b0);
      exp_st(F, 9'h004, LKT + 60);
      dis(1'b1, 1'b1);
      repeat (RDQ + 20) @(posedge clk_in);
      exp_st(9'h01b, 9'h018, 0);
      dis(1'b0, 1'b0);
      exp_st(F, 9'h004, LKT + 60);
      mode(2'b00);
      // let the mode pins sync through before the range flag moves
      repeat (4) @(posedge clk_in);
      oor(1'b1, 1'b0);
      repeat (20) @(posedge clk_in);
      exp_st(9'h01b, 9'h000, 0);
      oor(1'b0, 1'b0);
      bus(1'b1, 4'h0, 32'h0001_0040);
      rdc(4'h0, 32'h0001_0040);
      secondary_master_sel_in <= 1'b1;
      chs <= 2'b10;
      men <= 1'b1;
      exp_st(9'h1e3, 9'h142, 3000);
      fp_period(16 * mcyc);
      mcyc <= 16'h003f;
      bus(1'b1, 4'h0, 32'h0000_0040);
      exp_st(9'h1e3, 9'h022, 3000);
      // promote keeping input b: holdover, primary, choice, normal, auto
      mode(2'b01);
      secondary_master_sel_in <= 1'b0;
      chs <= 2'b01;
      repeat (4) @(posedge clk_in);
      mode(2'b00);
      repeat (4) @(posedge clk_in);
      mode(2'b11);
      repeat (8) @(posedge clk_in);
      exp_st(9'h0e3, 9'h081, 100);
      mode(2'b00);
      chs <= 2'b10;
      repeat (4) @(posedge clk_in);
      mode(2'b11);
      exp_st(9'h0e3, 9'h080, 100);
      test_done();
   end
endmodule
